// >>> hw/sdc_cascade.sv
// Cascade enable chain and display data loading of an 80-channel segment driver.
// Assumes all pins are asynchronous to i_sys_clk and far slower than 25 MHz.
//
// How it works
// - Direction low: right pin is enable input, left pin enable output.
// - Direction high: left pin is enable input, right pin enable output.
// - In common-driver mode the enable chain has no effect.
// - Four-bit parallel mode: handoff after 20 shift clocks.
// - One-bit serial mode: handoff after 80 shift clocks.
`timescale 1ns/1ns
`include "sdc_regs.svh"
module sdc_cascade (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic i_shift_clk,
	input wire logic i_latch_clk,
	input wire logic [3:0] i_data,
	input wire logic i_shift_direction_select,
	input wire logic i_application_mode_select,
	input wire logic i_com_seg_select,
	input wire logic i_left_enable_pin,
	input wire logic i_right_enable_pin,
	output logic o_left_enable_pin,
	output logic o_left_enable_pin_oe,
	output logic o_right_enable_pin,
	output logic o_right_enable_pin_oe,
	output logic o_enabled,
	output logic [`SDC_SEG_W-1:0] o_seg_data
);

	// Synchronised copies of every pin; nothing below reads a raw pin
	logic [`SDC_SYNC_W-1:0] pins_s;
	logic sck_s, lck_s, shl_s, ams_s, cs_s, len_s, ren_s;
	logic [3:0] data_s;
	logic sck_prev_q, lck_prev_q;
	logic sck_rise, lck_rise;
	logic en_in, en_ok;
	logic [`SDC_CNT_W-1:0] cnt_q, n_target;
	logic [`SDC_SEG_W-1:0] shift_q;
	logic eo_q;
	sdc_pkg::sdc_state_t state_q;

	sdc_sync #(
		.W(`SDC_SYNC_W)
	) u_sync (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_async({i_shift_clk, i_latch_clk, i_data, i_shift_direction_select,
			i_application_mode_select, i_com_seg_select, i_left_enable_pin,
			i_right_enable_pin}),
		.o_sync(pins_s)
	);

	// Unpack in the packing order above; the widths add up to the sync width
	assign {sck_s, lck_s, data_s, shl_s, ams_s, cs_s, len_s, ren_s} = pins_s;

	// Edge detectors read only the synchronised copies
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sck_prev_q <= 1'b0;
			lck_prev_q <= 1'b0;
		end else begin
			sck_prev_q <= sck_s;
			lck_prev_q <= lck_s;
		end
	end

	assign sck_rise = sck_s && !sck_prev_q;
	assign lck_rise = lck_s && !lck_prev_q;

	// Enable input depends on direction; active low
	assign en_in = shl_s ? len_s : ren_s;
	// Segment mode only; common mode never loads segment data here
	assign en_ok = !cs_s && !en_in;
	// Mode is read per edge; changing it in mid-line mixes the two counts
	assign n_target = ams_s ? `SDC_N_SERIAL : `SDC_N_PARALLEL;

	// Load sequence: wait for enable, count shift clocks, hand off
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q <= sdc_pkg::SDC_ST_WAIT;
			cnt_q <= '0;
			eo_q <= `SDC_EO_RESET;
		end else if (lck_rise) begin
			// A line latch restarts the chain so the first driver loads next
			state_q <= sdc_pkg::SDC_ST_WAIT;
			cnt_q <= '0;
			eo_q <= `SDC_EO_RESET;
		end else if (sck_rise && en_ok) begin
			unique case (state_q)
				sdc_pkg::SDC_ST_WAIT, sdc_pkg::SDC_ST_LOAD: begin
					cnt_q <= cnt_q + `SDC_CNT_W'(1);
					if (cnt_q + `SDC_CNT_W'(1) == n_target) begin
						state_q <= sdc_pkg::SDC_ST_DONE;
						eo_q <= 1'b0;
					end else begin
						state_q <= sdc_pkg::SDC_ST_LOAD;
					end
				end
				sdc_pkg::SDC_ST_DONE: begin
					// Full; extra clocks belong to the next driver
					cnt_q <= cnt_q;
				end
			endcase
		end
	end

	// Shift register; a full driver stops shifting so data is not pushed out
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			shift_q <= '0;
		end else if (sck_rise && en_ok && state_q != sdc_pkg::SDC_ST_DONE) begin
			if (!ams_s) begin
				shift_q <= shl_s ? {data_s, shift_q[79:4]} : {shift_q[75:0], data_s};
			end else begin
				shift_q <= shl_s ? {data_s[0], shift_q[79:1]} : {shift_q[78:0], data_s[0]};
			end
		end
	end

	// Latch copy on the line clock; common mode leaves latch to another path
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_seg_data <= '0;
		end else if (lck_rise && !cs_s) begin
			o_seg_data <= shift_q;
		end
	end

	// Enable output pins, registered; only the output side is driven
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_left_enable_pin <= `SDC_EO_RESET;
			o_right_enable_pin <= `SDC_EO_RESET;
			o_left_enable_pin_oe <= 1'b0;
			o_right_enable_pin_oe <= 1'b0;
			o_enabled <= 1'b0;
		end else begin
			o_left_enable_pin <= eo_q;
			o_right_enable_pin <= eo_q;
			o_left_enable_pin_oe <= !cs_s && !shl_s;
			o_right_enable_pin_oe <= !cs_s && shl_s;
			o_enabled <= en_ok;
		end
	end

	// Checks work on the synced pins, so they see what the logic sees
	AST_LEFT_IS_OUTPUT: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(!shl_s && !cs_s) |=> (o_left_enable_pin_oe && !o_right_enable_pin_oe))
		else $error("left pin not driven as enable output");

	AST_RIGHT_IS_OUTPUT: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(shl_s && !cs_s) |=> (o_right_enable_pin_oe && !o_left_enable_pin_oe))
		else $error("right pin not driven as enable output");

	AST_COMMON_NO_CHAIN: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(cs_s && !lck_rise) |=> (!o_left_enable_pin_oe && !o_right_enable_pin_oe
			&& $stable(shift_q)))
		else $error("enable chain active in common mode");

	AST_PARALLEL_HANDOFF: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(!ams_s && sck_rise && en_ok && !lck_rise && cnt_q == 7'h13
			&& state_q == sdc_pkg::SDC_ST_LOAD) |=> (!eo_q ##1 !o_left_enable_pin))
		else $error("parallel handoff not after twenty clocks");

	AST_SERIAL_HANDOFF: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(ams_s && sck_rise && en_ok && !lck_rise && cnt_q == 7'h4f
			&& state_q == sdc_pkg::SDC_ST_LOAD) |=> (state_q == sdc_pkg::SDC_ST_DONE && !eo_q))
		else $error("serial handoff not after eighty clocks");

	AST_SERIAL_NOT_EARLY: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(ams_s && !lck_rise && state_q != sdc_pkg::SDC_ST_DONE && cnt_q < 7'h4f) |=> eo_q)
		else $error("serial handoff too early");

	AST_DISABLED_IGNORES: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(!en_ok && !lck_rise) |=> ($stable(shift_q) && $stable(cnt_q) && $stable(o_seg_data)))
		else $error("disabled driver changed its data");

	AST_LATCH_COPY: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(lck_rise && !cs_s) |=> (o_seg_data == $past(shift_q) && cnt_q == '0))
		else $error("latch did not copy shift data");

	AST_LATCH_RESTARTS: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		lck_rise |=> (state_q == sdc_pkg::SDC_ST_WAIT && eo_q && cnt_q == '0))
		else $error("latch did not restart the chain");

	AST_PARALLEL_NOT_EARLY: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(!ams_s && !lck_rise && state_q != sdc_pkg::SDC_ST_DONE && cnt_q < 7'h13) |=> eo_q)
		else $error("parallel handoff too early");

	AST_COUNT_STEP: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(sck_rise && en_ok && !lck_rise && state_q != sdc_pkg::SDC_ST_DONE)
			|=> (cnt_q == $past(cnt_q) + 7'h01))
		else $error("accepted shift edge not counted");

	AST_FULL_HOLDS: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(state_q == sdc_pkg::SDC_ST_DONE && !lck_rise) |=> ($stable(shift_q) && !eo_q))
		else $error("full driver kept shifting or released its output");

	AST_RIGHT_PIN_GATES: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(!cs_s && !shl_s) |=> (o_enabled == !$past(ren_s)))
		else $error("right enable input does not gate the driver");

	AST_LEFT_PIN_GATES: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(!cs_s && shl_s) |=> (o_enabled == !$past(len_s)))
		else $error("left enable input does not gate the driver");

	AST_COMMON_DISABLED: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		cs_s |=> !o_enabled)
		else $error("driver enabled in common mode");

	AST_DISABLED_NO_HANDOFF: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(!en_ok && !lck_rise) |=> $stable(eo_q))
		else $error("disabled driver moved its enable output");

	AST_PINS_FOLLOW_FLAG: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(o_left_enable_pin == $past(eo_q) && o_right_enable_pin == $past(eo_q)))
		else $error("enable output pins do not follow the handoff flag");

	AST_ONE_SIDE_DRIVEN: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		!(o_left_enable_pin_oe && o_right_enable_pin_oe))
		else $error("both enable pins driven at once");

endmodule

// >>> hw/sdc_regs.svh
// Shift counts and reset values for the segment driver cascade block.
// Included by name; holds definitions only.
`ifndef SDC_REGS_SVH
`define SDC_REGS_SVH

`define SDC_CNT_W 7
`define SDC_N_PARALLEL 7'h14
`define SDC_N_SERIAL 7'h50
`define SDC_SEG_W 80
`define SDC_SYNC_W 11
`define SDC_EO_RESET 1'b1

`endif

// >>> hw/sdc_pkg.sv
// Types shared by the segment driver cascade block.
// Assumes sdc_regs.svh is compiled alongside.
package sdc_pkg;

	typedef enum logic [2:0] {
		SDC_ST_WAIT = 3'h1,
		SDC_ST_LOAD = 3'h2,
		SDC_ST_DONE = 3'h4
	} sdc_state_t;

endpackage

// >>> hw/sdc_sync.sv
// Two-flop synchroniser for a group of pin inputs.
// Assumes every bit is a slow level, so per-bit skew is harmless.
`timescale 1ns/1ns
module sdc_sync #(
	parameter int W = 1
) (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);

	logic [W-1:0] meta_q;

	// One pair of flops per bit; first stage feeds only the second
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge i_sys_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					meta_q[g] <= 1'b0;
					o_sync[g] <= 1'b0;
				end else begin
					meta_q[g] <= i_async[g];
					o_sync[g] <= meta_q[g];
				end
			end
		end
	endgenerate

endmodule

// >>> test/sdc_ctl_model.sv
// Controller model: drives the shift clock, latch clock and data pins.
// Assumes its task is called just after a falling edge of i_sys_clk.
`timescale 1ns/1ns
module sdc_ctl_model (
	input wire logic i_sys_clk,
	output logic o_sck,
	output logic o_lck,
	output logic [3:0] o_data
);
	initial begin
		o_sck = 1'b0;
		o_lck = 1'b0;
		o_data = 4'h0;
	end
	// The high level lasts four cycles, the low at least six, so the synchroniser never misses an edge
	task pulse(input logic lck, input logic [3:0] d);
		o_data = d;
		repeat (2) @(negedge i_sys_clk);
		if (lck) o_lck = 1'b1;
		else o_sck = 1'b1;
		repeat (4) @(negedge i_sys_clk);
		o_sck = 1'b0;
		o_lck = 1'b0;
		repeat (2) @(negedge i_sys_clk);
		o_data = ~d; // Data past its hold time shows a changed pattern
		repeat (2) @(negedge i_sys_clk);
	endtask
endmodule

// >>> test/testbench.sv
// Self-checking bench for the cascade enable chain and data loading.
// Assumes the controller model and design files are compiled first.
`timescale 1ns/1ns
module testbench;
	logic clk, rstn, dir, application_mode_select, cs, en_n, ol, ole, orr, ore, oen, pin, oe;
	logic [79:0] seg, sr, seg_seen;
	logic [79:0] q[$];
	wire sck, lck, l_pin, r_pin;
	wire [3:0] d;
	int err_count, comparisons, cyc;
	// Unused pin side pulled up; neighbour output feeds our input
	assign l_pin = ole ? ol : (dir ? en_n : 1'b1);
	assign r_pin = ore ? orr : (dir ? 1'b1 : en_n);
	assign pin = dir ? orr : ol;
	assign oe = dir ? ore : ole;
	sdc_ctl_model i_ctl (.i_sys_clk(clk), .o_sck(sck), .o_lck(lck), .o_data(d));
	sdc_cascade i_dut (.i_sys_clk(clk), .i_rstn(rstn), .i_shift_clk(sck), .i_latch_clk(lck),
		.i_data(d), .i_shift_direction_select(dir), .i_application_mode_select(application_mode_select),
		.i_com_seg_select(cs), .i_left_enable_pin(l_pin), .i_right_enable_pin(r_pin),
		.o_left_enable_pin(ol), .o_left_enable_pin_oe(ole), .o_right_enable_pin(orr),
		.o_right_enable_pin_oe(ore), .o_enabled(oen), .o_seg_data(seg));
	task chk(input string n, input logic [79:0] s, input logic [79:0] e);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Load n units, check the handoff moment, then latch
	task run(input logic di, input logic am, input int n);
		logic [3:0] v;
		dir = di;
		application_mode_select = am;
		repeat (4) @(negedge clk);
		for (int i = 0; i < n; i++) begin
			v = $urandom;
			if (!en_n) sr = di ? (am ? {v[0], sr[79:1]} : {v, sr[79:4]})
				: (am ? {sr[78:0], v[0]} : {sr[75:0], v});
			chk("pin before n", pin, 1'b1);
			i_ctl.pulse(1'b0, v);
		end
		chk("pin after n", pin, en_n);
		chk("out oe", oe, 1'b1);
		chk("in oe", di ? ole : ore, 1'b0);
		chk("enabled", oen, !en_n);
		if (!en_n) q.push_back(sr);
		i_ctl.pulse(1'b1, 4'h0);
		chk("pin after latch", pin, 1'b1);
		$display("test dir %0d mode %0d off %0d done", di, am, en_n);
	endtask
	// Watcher: each new latched line must match the oldest note
	always @(negedge clk) begin
		if (rstn === 1'b1 && seg !== seg_seen) begin
			if (q.size() == 0) chk("seg_data", seg, seg_seen);
			else chk("seg_data", seg, q.pop_front());
		end
		seg_seen = seg;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			err_count++;
			give_verdict();
		end
	end
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		{rstn, dir, application_mode_select, cs, en_n, sr} = '0;
		void'($urandom(32'hfaae742d));
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		run(1'b0, 1'b0, 20);
		run(1'b1, 1'b1, 80);
		run(1'b1, 1'b0, 20);
		en_n = 1'b1;
		run(1'b0, 1'b1, 80);
		en_n = 1'b0;
		cs = 1'b1;
		repeat (6) @(negedge clk);
		chk("oe in common mode", {ole, ore, oen}, 3'h0);
		for (int i = 0; i < 20; i++) i_ctl.pulse(1'b0, 4'h5);
		chk("pin in common mode", pin, 1'b1);
		i_ctl.pulse(1'b1, 4'h0);
		$display("test common mode done");
		repeat (8) @(negedge clk);
		give_verdict();
	end
endmodule
